// [hdl/pplh_pkg.sv]
package pplh_pkg;

  // clock and control timing
  localparam int CLK_KHZ    = 250000;
  localparam int PERIOD_MS  = 16;
  localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;
  localparam int FLASH_MS   = 50;
  localparam int FLASH_CYC  = FLASH_MS * CLK_KHZ;

  // power scale and fault threshold (25 % rounded up)
  localparam int PWR_FULL_I  = 127;
  localparam int FAULT_PCT   = 25;
  localparam logic signed [7:0] PWR_MAX   = 8'sh7f;
  localparam logic signed [7:0] PWR_MIN   = -8'sh7f;
  localparam logic [7:0] FAULT_PWR =
    8'((PWR_FULL_I * FAULT_PCT + 99) / 100);

  // gain fixed point and integrator bound
  localparam int GAIN_SHIFT = 4;
  localparam logic signed [15:0] INTEG_MAX = 16'sh0fff;
  localparam logic signed [15:0] INTEG_MIN = -16'sh0fff;

  // status display codes
  localparam logic [3:0] DIGIT_ENC_FAULT = 4'h8;
  localparam logic [3:0] DIGIT_NONE      = 4'h0;
  localparam logic [1:0] CLASS_NORMAL    = 2'h0;
  localparam logic [1:0] CLASS_PERM      = 2'h2;

  // register byte offsets
  localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
  localparam logic [31:0] REG_GAINS  = 32'h0000_0004;
  localparam logic [31:0] REG_CMD    = 32'h0000_0008;
  localparam logic [31:0] REG_STATUS = 32'h0000_000c;
  localparam logic [31:0] REG_POS    = 32'h0000_0010;

  // reset values
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam logic [23:0] GAINS_RST = 24'h00_00_10;
  localparam logic [15:0] CMD_RST   = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] kd;
    logic [7:0] ki;
    logic [7:0] kp;
  } pplh_gains_t;

  typedef struct packed {
    logic enc_chk;
    logic ana_cmd;
    logic run;
  } pplh_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_STOP = 2'b10,
    ST_HALT = 2'b11
  } pplh_state_t;

  // magnitude at or above the fault threshold
  function automatic logic is_high(input logic signed [7:0] p);
    logic [7:0] mag;
    mag = p[7] ? 8'(-p) : 8'(p);
    return mag >= FAULT_PWR;
  endfunction

endpackage

// [hdl/pplh_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module pplh_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // two stage capture of pin levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else if (ce)
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

`default_nettype wire

// [hdl/pplh_pid_chan.sv]
`timescale 1ns/1ps
`default_nettype none

module pplh_pid_chan (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic                 tick,
  input  wire logic                 hold,
  input  wire pplh_pkg::pplh_gains_t gains,
  input  wire logic signed [7:0]    cmd,
  input  wire logic signed [7:0]    fb,
  output logic signed [7:0]         power,
  output logic signed [8:0]         err
);

  logic signed [15:0] integ_q;
  logic signed [8:0]  err_d;
  logic signed [9:0]  derr;
  logic signed [16:0] integ_sum;
  logic signed [15:0] integ_d;
  logic signed [27:0] p_term;
  logic signed [27:0] i_term;
  logic signed [27:0] d_term;
  logic signed [27:0] sum;
  logic signed [27:0] scaled;
  logic signed [7:0]  power_d;

  // error, its change and the bounded running sum
  assign err_d     = 9'(cmd) - 9'(fb);
  assign derr      = 10'(err_d) - 10'(err);
  assign integ_sum = 17'(integ_q) + 17'(err_d);
  assign integ_d   = (integ_sum > 17'(pplh_pkg::INTEG_MAX))
                   ? pplh_pkg::INTEG_MAX
                   : (integ_sum < 17'(pplh_pkg::INTEG_MIN))
                   ? pplh_pkg::INTEG_MIN
                   : 16'(integ_sum);

  // three gain products, shared gain set
  assign p_term = 28'(signed'({1'b0, gains.kp})) * 28'(err_d);
  assign i_term = 28'(signed'({1'b0, gains.ki})) * 28'(integ_d);
  assign d_term = 28'(signed'({1'b0, gains.kd})) * 28'(derr);
  assign sum    = p_term + i_term + d_term;
  assign scaled = sum >>> pplh_pkg::GAIN_SHIFT;
  assign power_d = (scaled > 28'(pplh_pkg::PWR_MAX)) ? pplh_pkg::PWR_MAX
                 : (scaled < 28'(pplh_pkg::PWR_MIN)) ? pplh_pkg::PWR_MIN
                 : 8'(scaled);

  // update once per control period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      integ_q <= '0;
      err     <= '0;
      power   <= '0;
    end
    else if (ce && tick)
    begin
      err     <= err_d;
      integ_q <= hold ? 16'sh0000 : integ_d;
      power   <= hold ? 8'sh00 : power_d;
    end
  end

  AST_ERR_SAMPLE: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && tick |=> err == $past(err_d))
    else $error("error not sampled at period tick");

  AST_P_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && tick && !hold && gains.ki == 8'h00 && gains.kd == 8'h00
    && err_d == 9'sh000 |=> power == 8'sh00)
    else $error("power not zero with zero error");

  AST_SAT: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && tick && !hold && sum > 28'sh00007ff
    |=> power == pplh_pkg::PWR_MAX)
    else $error("output not saturated");

endmodule

`default_nettype wire

// [hdl/pplh_top.sv]
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pplh_top #(
  parameter int PERIOD_CYC = pplh_pkg::PERIOD_CYC,
  parameter int FLASH_CYC  = pplh_pkg::FLASH_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  ana_in1,
  input  wire logic [7:0]  ana_in2,
  input  wire logic [7:0]  ana_in3,
  input  wire logic [7:0]  ana_in4,
  input  wire logic        estop_in,
  input  wire logic [1:0]  enc_a,
  input  wire logic [1:0]  enc_b,
  output logic [7:0]       mot_pwr1,
  output logic [7:0]       mot_pwr2,
  output logic             mot_en,
  output logic [3:0]       disp_digit,
  output logic             disp_lit,
  output logic [1:0]       disp_class
);

  // apply byte enables to a register word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

  pplh_pkg::pplh_ctrl_t  ctrl_q;
  pplh_pkg::pplh_gains_t gains_q;
  pplh_pkg::pplh_state_t st_q;
  pplh_pkg::pplh_state_t st_d;
  logic [15:0]        cmd_q;
  logic [31:0]        awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               aw_full_q;
  logic               w_full_q;
  logic [31:0]        per_cnt_q;
  logic               tick_q;
  logic [31:0]        fl_cnt_q;
  logic               flash_q;
  logic [3:0]         enc_p_q;
  logic               moved_q;
  logic [36:0]        pins_s;
  logic [7:0]         a1_s;
  logic [7:0]         a2_s;
  logic [7:0]         a3_s;
  logic [7:0]         a4_s;
  logic               estop_s;
  logic [3:0]         enc_s;
  logic signed [7:0]  fb1;
  logic signed [7:0]  fb2;
  logic signed [7:0]  cmd1;
  logic signed [7:0]  cmd2;
  logic signed [7:0]  pid1;
  logic signed [7:0]  pid2;
  logic signed [8:0]  err1;
  logic signed [8:0]  err2;
  logic               hold;
  logic               halt_hit;
  logic               run_ok;
  logic               moved_now;
  logic               aw_hs;
  logic               w_hs;
  logic               ar_hs;
  logic               wr_go;
  logic               wr_ctrl;
  logic               wr_gains;
  logic               wr_cmd;
  logic               wr_hit;
  logic               rd_hit;
  logic [31:0]        rd_word;

  // all pin inputs pass two flops
  pplh_sync #(.W(37)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     ({ana_in1, ana_in2, ana_in3, ana_in4, estop_in, enc_a, enc_b}),
    .dout    (pins_s)
  );
  assign {a1_s, a2_s, a3_s, a4_s, estop_s, enc_s} = pins_s;

  // command and feedback source selection
  assign fb1  = ctrl_q.ana_cmd ? a3_s : a1_s;
  assign fb2  = ctrl_q.ana_cmd ? a4_s : a2_s;
  assign cmd1 = ctrl_q.ana_cmd ? a1_s : cmd_q[7:0];
  assign cmd2 = ctrl_q.ana_cmd ? a2_s : cmd_q[15:8];
  assign hold = (st_q != pplh_pkg::ST_RUN);

  // one loop per channel, same gain set
  pplh_pid_chan u_pid1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tick    (tick_q),
    .hold    (hold),
    .gains   (gains_q),
    .cmd     (cmd1),
    .fb      (fb1),
    .power   (pid1),
    .err     (err1)
  );
  pplh_pid_chan u_pid2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tick    (tick_q),
    .hold    (hold),
    .gains   (gains_q),
    .cmd     (cmd2),
    .fb      (fb2),
    .power   (pid2),
    .err     (err2)
  );

  // control period and flash timers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      per_cnt_q <= '0;
      tick_q    <= 1'b0;
      fl_cnt_q  <= '0;
      flash_q   <= 1'b0;
    end
    else if (ce)
    begin
      tick_q    <= (per_cnt_q == 32'(PERIOD_CYC - 2));
      per_cnt_q <= (per_cnt_q == 32'(PERIOD_CYC - 1)) ? '0 : per_cnt_q + 1;
      if (fl_cnt_q == 32'(FLASH_CYC - 1))
      begin
        fl_cnt_q <= '0;
        flash_q  <= ~flash_q;
      end
      else
        fl_cnt_q <= fl_cnt_q + 1;
    end
  end

  // encoder motion seen during the current period
  assign moved_now = |(enc_s ^ enc_p_q);
  assign halt_hit  = tick_q && ctrl_q.enc_chk && !moved_q && !moved_now
                   && (pplh_pkg::is_high(mot_pwr1)
                   || pplh_pkg::is_high(mot_pwr2));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enc_p_q <= '0;
      moved_q <= 1'b0;
    end
    else if (ce)
    begin
      enc_p_q <= enc_s;
      moved_q <= moved_now | (moved_q & ~tick_q); // motion on tick kept
    end
  end

  // controller state, halt leaves only by reset
  always_comb
  begin
    case (st_q)
      pplh_pkg::ST_HALT:
        st_d = pplh_pkg::ST_HALT;
      pplh_pkg::ST_RUN:
        if (halt_hit)
          st_d = pplh_pkg::ST_HALT;
        else if (estop_s)
          st_d = pplh_pkg::ST_STOP;
        else if (!ctrl_q.run)
          st_d = pplh_pkg::ST_IDLE;
        else
          st_d = pplh_pkg::ST_RUN;
      pplh_pkg::ST_STOP:
        st_d = estop_s ? pplh_pkg::ST_STOP : pplh_pkg::ST_IDLE;
      pplh_pkg::ST_IDLE:
        st_d = (ctrl_q.run && !estop_s) ? pplh_pkg::ST_RUN
                                        : (estop_s ? pplh_pkg::ST_STOP
                                                   : pplh_pkg::ST_IDLE);
      default:
        st_d = pplh_pkg::ST_IDLE;
    endcase
  end

  assign run_ok = (st_d == pplh_pkg::ST_RUN) && !estop_s;

  // motor drive and status display
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q       <= pplh_pkg::ST_IDLE;
      mot_pwr1   <= '0;
      mot_pwr2   <= '0;
      mot_en     <= 1'b0;
      disp_digit <= pplh_pkg::DIGIT_NONE;
      disp_lit   <= 1'b0;
      disp_class <= pplh_pkg::CLASS_NORMAL;
    end
    else if (ce)
    begin
      st_q     <= st_d;
      mot_pwr1 <= run_ok ? pid1 : 8'h00;
      mot_pwr2 <= run_ok ? pid2 : 8'h00;
      mot_en   <= run_ok;
      if (st_d == pplh_pkg::ST_HALT)
      begin
        disp_digit <= pplh_pkg::DIGIT_ENC_FAULT;
        disp_lit   <= flash_q;
        disp_class <= pplh_pkg::CLASS_PERM;
      end
      else
      begin
        disp_digit <= pplh_pkg::DIGIT_NONE;
        disp_lit   <= 1'b1;
        disp_class <= pplh_pkg::CLASS_NORMAL;
      end
    end
  end

  // bus handshakes and address decode
  assign aw_hs    = s_axi_awvalid && s_axi_awready;
  assign w_hs     = s_axi_wvalid && s_axi_wready;
  assign ar_hs    = s_axi_arvalid && s_axi_arready;
  assign wr_go    = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_ctrl  = wr_go && (awaddr_q == pplh_pkg::REG_CTRL);
  assign wr_gains = wr_go && (awaddr_q == pplh_pkg::REG_GAINS);
  assign wr_cmd   = wr_go && (awaddr_q == pplh_pkg::REG_CMD);
  assign wr_hit   = (awaddr_q == pplh_pkg::REG_CTRL)
                 || (awaddr_q == pplh_pkg::REG_GAINS)
                 || (awaddr_q == pplh_pkg::REG_CMD)
                 || (awaddr_q == pplh_pkg::REG_STATUS)
                 || (awaddr_q == pplh_pkg::REG_POS);
  assign rd_hit   = (s_axi_araddr == pplh_pkg::REG_CTRL)
                 || (s_axi_araddr == pplh_pkg::REG_GAINS)
                 || (s_axi_araddr == pplh_pkg::REG_CMD)
                 || (s_axi_araddr == pplh_pkg::REG_STATUS)
                 || (s_axi_araddr == pplh_pkg::REG_POS);
  assign rd_word  =
      (s_axi_araddr == pplh_pkg::REG_CTRL)   ? {29'h0, ctrl_q}
    : (s_axi_araddr == pplh_pkg::REG_GAINS)  ? {8'h00, gains_q}
    : (s_axi_araddr == pplh_pkg::REG_CMD)    ? {16'h0000, cmd_q}
    : (s_axi_araddr == pplh_pkg::REG_STATUS) ? {8'h00, mot_pwr2, mot_pwr1,
                                                5'h00, mot_en, estop_s,
                                                (st_q == pplh_pkg::ST_HALT)}
    : (s_axi_araddr == pplh_pkg::REG_POS)    ? {err2[8:1], err1[8:1],
                                                fb2, fb1}
    : 32'h0000_0000;

  // write channel: address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pplh_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_hs)
      begin
        awaddr_q      <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_hs)
      begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? pplh_pkg::RESP_OKAY : pplh_pkg::RESP_SLVERR;
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // writable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q  <= pplh_pkg::CTRL_RST;
      gains_q <= pplh_pkg::GAINS_RST;
      cmd_q   <= pplh_pkg::CMD_RST;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_q <= 3'(merge({29'h0, ctrl_q}, wdata_q, wstrb_q));
      if (wr_gains)
        gains_q <= 24'(merge({8'h00, gains_q}, wdata_q, wstrb_q));
      if (wr_cmd)
        cmd_q <= 16'(merge({16'h0000, cmd_q}, wdata_q, wstrb_q));
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pplh_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? pplh_pkg::RESP_OKAY : pplh_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  AST_HALT_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st_q == pplh_pkg::ST_RUN && halt_hit
    |=> st_q == pplh_pkg::ST_HALT && mot_pwr1 == 8'h00)
    else $error("encoder fault did not halt");

  AST_HALT_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == pplh_pkg::ST_HALT |=> st_q == pplh_pkg::ST_HALT
    && mot_pwr1 == 8'h00 && mot_pwr2 == 8'h00 && !mot_en)
    else $error("halt released or power applied");

  AST_DISP8: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == pplh_pkg::ST_HALT && ce |=> disp_digit == pplh_pkg::DIGIT_ENC_FAULT
    && disp_class == pplh_pkg::CLASS_PERM)
    else $error("fault digit not shown");

  AST_ESTOP: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && estop_s |=> mot_pwr1 == 8'h00 && mot_pwr2 == 8'h00 && !mot_en)
    else $error("emergency stop did not disable both channels");

  AST_FB_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q.ana_cmd |-> fb1 == a3_s && fb2 == a4_s && cmd1 == a1_s)
    else $error("analog mode feedback routing wrong");

  AST_TICK_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && tick_q |=> !tick_q)
    else $error("period tick lasted more than one cycle");

endmodule

`default_nettype wire

// [test/pplh_plant.sv]
`timescale 1ns/1ps
`default_nettype none

module pplh_plant (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       amode,
  input  wire logic       stall,
  input  wire logic [7:0] pos1,
  input  wire logic [7:0] pos2,
  input  wire logic [7:0] acmd1,
  input  wire logic [7:0] acmd2,
  input  wire logic [7:0] mot_pwr1,
  input  wire logic [7:0] mot_pwr2,
  output logic      [7:0] ana_in1,
  output logic      [7:0] ana_in2,
  output logic      [7:0] ana_in3,
  output logic      [7:0] ana_in4,
  output logic      [1:0] enc_a,
  output logic      [1:0] enc_b
);
  logic [1:0] ph1_q;
  logic [1:0] ph2_q;

  // sensor on 1,2; analog command mode puts it on 3,4
  assign ana_in1 = amode ? acmd1 : pos1;
  assign ana_in2 = amode ? acmd2 : pos2;
  assign ana_in3 = amode ? pos1 : ~pos1;
  assign ana_in4 = amode ? pos2 : ~pos2;
  assign enc_a   = {ph2_q[1], ph1_q[1]};
  assign enc_b   = {ph2_q[1] ^ ph2_q[0], ph1_q[1] ^ ph1_q[0]};

  // shaft turns under power unless jammed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph1_q <= 2'h0;
      ph2_q <= 2'h0;
    end
    else
    begin
      if (!stall && mot_pwr1 != 8'h00)
        ph1_q <= ph1_q + 2'h1;
      if (!stall && mot_pwr2 != 8'h00)
        ph2_q <= ph2_q + 2'h1;
    end
  end
endmodule

`default_nettype wire

// [test/pplh_top_test.sv]
`timescale 1ns/1ps
`default_nettype none

module pplh_top_test;
  localparam int P = 20;
  logic        aclk, aresetn, estop_in, amode, stall, mot_en, disp_lit, ce;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, enc_a, enc_b, disp_class;
  logic [3:0]  disp_digit;
  logic [7:0]  ana_in1, ana_in2, ana_in3, ana_in4, mot_pwr1, mot_pwr2;
  logic [7:0]  pos1, pos2, acmd1, acmd2, a;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  int          bad_count, compares, n;

  pplh_top #(.PERIOD_CYC(P), .FLASH_CYC(4)) u_pplh_top (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ana_in1, .ana_in2,
    .ana_in3, .ana_in4, .estop_in, .enc_a, .enc_b, .mot_pwr1, .mot_pwr2,
    .mot_en, .disp_digit, .disp_lit, .disp_class);

  pplh_plant u_pplh_plant (
    .aclk, .aresetn, .amode, .stall, .pos1, .pos2, .acmd1, .acmd2,
    .mot_pwr1, .mot_pwr2, .ana_in1, .ana_in2, .ana_in3, .ana_in4,
    .enc_a, .enc_b);

  // 250 MHz clock
  initial
  begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [31:0] ad, input logic [31:0] d,
                    input logic [1:0] e);
    logic aw;
    logic w;
    int   k;
    aw = 1'h1;
    w = 1'h1;
    k = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      k++;
      if (aw && s_axi_awready === 1'h1)
      begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1)
      begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end while ((aw || w || s_axi_bvalid !== 1'h1) && k < 200);
    chk("bresp", e, s_axi_bresp);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [31:0] ad, input logic [31:0] ed,
                    input logic [1:0] e);
    int k;
    k = 0;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && k < 200);
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", e, s_axi_rresp);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic pw(input logic [7:0] e1, input logic [7:0] e2);
    chk("mot_pwr1", e1, mot_pwr1);
    chk("mot_pwr2", e2, mot_pwr2);
  endtask

  // a full period stopped clears the integrator, then gains, targets, mode
  task automatic setup(input logic [2:0] c, input logic [23:0] g,
                       input logic [7:0] c1, input logic [7:0] c2);
    wr(pplh_pkg::REG_CTRL, 32'h0, 2'h0);
    cyc(P);
    wr(pplh_pkg::REG_GAINS, {8'h0, g}, 2'h0);
    wr(pplh_pkg::REG_CMD, {16'h0, c2, c1}, 2'h0);
    wr(pplh_pkg::REG_CTRL, {29'h0, c}, 2'h0);
  endtask

  task automatic rst;
    aresetn <= 1'h0;
    cyc(20);
    aresetn <= 1'h1;
    cyc(1);
  endtask

  task automatic t_reset;
    pw(8'h0, 8'h0);
    chk("mot_en", 1'h0, mot_en);
    rd(pplh_pkg::REG_CTRL, 32'h0, 2'h0);
    rd(pplh_pkg::REG_GAINS, 32'h10, 2'h0);
    rd(pplh_pkg::REG_CMD, 32'h0, 2'h0);
    wr(32'h20, 32'h1, 2'h2);
    rd(32'h20, 32'h0, 2'h2);
    $display("test reset done");
  endtask

  task automatic t_prop;
    pos1 <= 8'h00;
    pos2 <= 8'h0a;
    setup(3'h1, 24'h10, 8'h14, 8'he2);
    cyc(3 * P);
    pw(8'h14, 8'hd8);
    rd(pplh_pkg::REG_POS, 32'hec0a0a00, 2'h0);
    wr(pplh_pkg::REG_GAINS, 32'h20, 2'h0);
    cyc(3 * P);
    pw(8'h28, 8'hb0);
    wr(pplh_pkg::REG_CMD, 32'h0a00, 2'h0);
    cyc(3 * P);
    pw(8'h00, 8'h00);
    $display("test proportional done");
  endtask

  task automatic t_sat;
    pos2 <= 8'h00;
    setup(3'h1, 24'hff, 8'h64, 8'h9c);
    cyc(3 * P);
    pw(8'h7f, 8'h81);
    $display("test saturation done");
  endtask

  task automatic t_integ;
    setup(3'h1, 24'h1000, 8'h05, 8'h00);
    cyc(2 * P);
    a = mot_pwr1;
    cyc(P);
    chk("integ step", a + 8'h05, mot_pwr1);
    $display("test integral done");
  endtask

  task automatic t_diff;
    setup(3'h1, 24'h100000, 8'h00, 8'h00);
    cyc(2 * P);
    wr(pplh_pkg::REG_CMD, 32'h1e, 2'h0);
    n = 0;
    while (mot_pwr1 === 8'h00 && n < 3 * P)
    begin
      @(posedge aclk);
      n++;
    end
    chk("diff kick", 8'h1e, mot_pwr1);
    cyc(P);
    chk("diff after", 8'h00, mot_pwr1);
    $display("test differential done");
  endtask

  task automatic t_estop;
    setup(3'h1, 24'h10, 8'h14, 8'h00);
    cyc(3 * P);
    estop_in <= 1'h1;
    cyc(5);
    chk("mot_en", 1'h0, mot_en);
    cyc(3 * P);
    pw(8'h00, 8'h00);
    rd(pplh_pkg::REG_STATUS, 32'h2, 2'h0);
    estop_in <= 1'h0;
    cyc(3 * P);
    chk("mot_en", 1'h1, mot_en);
    pw(8'h14, 8'h00);
    $display("test stop done");
  endtask

  task automatic t_amode;
    amode <= 1'h1;
    pos1 <= 8'h05;
    acmd1 <= 8'h19;
    acmd2 <= 8'hf6;
    setup(3'h3, 24'h10, 8'h00, 8'h00);
    cyc(3 * P);
    pw(8'h14, 8'hf6);
    ce <= 1'h0;
    acmd1 <= 8'h28;
    cyc(3 * P);
    pw(8'h14, 8'hf6);
    ce <= 1'h1;
    cyc(3 * P);
    pw(8'h23, 8'hf6);
    amode <= 1'h0;
    pos1 <= 8'h00;
    $display("test analog mode done");
  endtask

  task automatic t_fault;
    rst();
    stall <= 1'h1;
    setup(3'h5, 24'h10, 8'h1f, 8'h00);
    cyc(3 * P);
    chk("class", 2'h0, disp_class);
    wr(pplh_pkg::REG_CMD, 32'h20, 2'h0);
    n = 0;
    while (disp_class !== 2'h2 && n < 3 * P)
    begin
      @(posedge aclk);
      n++;
    end
    chk("class", 2'h2, disp_class);
    chk("digit", 4'h8, disp_digit);
    pw(8'h00, 8'h00);
    a = {7'h0, disp_lit};
    cyc(4);
    chk("lit", {31'h0, ~a[0]}, disp_lit);
    stall <= 1'h0;
    cyc(3 * P);
    pw(8'h00, 8'h00);
    chk("class", 2'h2, disp_class);
    rst();
    chk("class", 2'h0, disp_class);
    chk("digit", 4'h0, disp_digit);
    $display("test encoder fault done");
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    summarize();
  end

  initial
  begin
    {aresetn, estop_in, amode, stall} = 4'h0;
    ce = 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {pos1, pos2, acmd1, acmd2} = 32'h0;
    bad_count = 0;
    compares = 0;
    @(posedge aclk);
    rst();
    t_reset();
    t_prop();
    t_sat();
    t_integ();
    t_diff();
    t_estop();
    t_amode();
    t_fault();
    summarize();
  end
endmodule

`default_nettype wire
